// ### core/dscic_pkg.sv
/*
 * Shared types and constants for the dual smart-card interface control.
 * Assumes the includer imports dscic_pkg::* and uses a 40 MHz core clock.
 */
package dscic_pkg;

    // number of card interfaces and their indices
    localparam int         DSCIC_NUM_IF    = 2;
    localparam int         DSCIC_IF_FIRST  = 0;
    localparam int         DSCIC_IF_SECOND = 1;

    // values after reset and fixed enables
    localparam logic       DSCIC_FIRST_EN_RST   = 1'h1;
    localparam logic       DSCIC_SECOND_EN_RST  = 1'h0;
    localparam logic       DSCIC_SWITCH_MODE_RST = 1'h0;
    localparam logic [1:0] DSCIC_PRESENT_RST    = 2'h0;
    // tray synchronisers start at the no-tray level, so no false insert
    localparam logic [1:0] DSCIC_TRAY_RST       = 2'h3;

    // card-switch select levels
    localparam logic       DSCIC_SEL_FIRST_CARD  = 1'h0;
    localparam logic       DSCIC_SEL_SECOND_CARD = 1'h1;

    // per-interface control state
    typedef enum logic [1:0] {
        DSCIC_ST_OFF    = 2'b00,
        DSCIC_ST_ACTIVE = 2'b01,
        DSCIC_ST_SHUT   = 2'b10
    } dscic_ifstate_t;

    // request from the card protocol logic, one per interface
    typedef struct packed {
        logic power_req;
        logic volt_1v8;
        logic reset_release;
        logic clk_run;
        logic io_drive_low;
    } dscic_user_req_t;

    // pad drive for one interface
    typedef struct packed {
        logic card_clock;
        logic card_supply_on;
        logic card_supply_1v8;
        logic card_reset;
        logic io_out;
        logic io_oe;
    } dscic_pad_out_t;

    // status toward the card protocol logic
    typedef struct packed {
        logic present;
        logic active;
        logic shut_down;
        logic io_level;
    } dscic_if_status_t;

endpackage : dscic_pkg

// ### core/dscic_pad_stage.sv
/*
 * Link-clock pad stage of one card interface: drives clock, supply,
 * reset and serial data pads. Assumes the enable level and request
 * bits come from the core domain and are stable for several link clocks.
 */
`timescale 1ns/1ps
module dscic_pad_stage (
    input  wire logic                      link_clk,
    input  wire logic                      arst_n,
    input  wire logic                      drive_on,
    input  wire dscic_pkg::dscic_user_req_t req,
    output dscic_pkg::dscic_pad_out_t      pad
);
    import dscic_pkg::*;

    typedef struct packed {
        logic            on_meta;
        logic            on_sync;
        dscic_user_req_t req_meta;
        dscic_user_req_t req_sync;
        logic            div;
        dscic_pad_out_t  pad;
    } dscic_pad_state_t;

    logic [1:0]       rst_pipe;
    logic             link_rst_n;
    dscic_pad_state_t s;
    dscic_pad_state_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // reset release synchronised to the link clock
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign link_rst_n = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////
    // enable and request cross as independent levels, two flops each
    always_comb begin
        next_s          = s;
        next_s.on_meta  = drive_on;
        next_s.on_sync  = s.on_meta;
        next_s.req_meta = req;
        next_s.req_sync = s.req_meta;
        if (s.on_sync) begin
            next_s.div                 = s.req_sync.clk_run ? ~s.div : 1'h0;
            next_s.pad.card_clock      = s.div;
            next_s.pad.card_supply_on  = 1'h1;
            next_s.pad.card_supply_1v8 = s.req_sync.volt_1v8;
            next_s.pad.card_reset      = s.req_sync.reset_release;
            next_s.pad.io_out          = 1'h0;
            next_s.pad.io_oe           = s.req_sync.io_drive_low;
        end else begin
            // off: everything low, data pulled down actively
            next_s.div                 = 1'h0;
            next_s.pad.card_clock      = 1'h0;
            next_s.pad.card_supply_on  = 1'h0;
            next_s.pad.card_supply_1v8 = 1'h0;
            next_s.pad.card_reset      = 1'h0;
            next_s.pad.io_out          = 1'h0;
            next_s.pad.io_oe           = 1'h1;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pad = s.pad;

    ////////////////////////////////////////////////////////////////////////
    a_off_pads_low: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        !s.on_sync |=> (!pad.card_clock && !pad.card_supply_on
                        && !pad.card_reset && pad.io_oe && !pad.io_out))
        else $error("pads not parked low while interface off");

    a_on_supply_up: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        s.on_sync |=> (pad.card_supply_on
                       && pad.card_supply_1v8 == $past(s.req_sync.volt_1v8)))
        else $error("card supply not matching requested class");

endmodule : dscic_pad_stage

// ### core/dscic_ctrl.sv
/*
 * Control of two smart-card interfaces: tray detection, shutdown on
 * removal, enable of the second interface, and the card-switch select
 * on the shared pin. Assumes the non-volatile switch mode is presented
 * as a steady level by storage, and that the link clock runs freely.
 */
`timescale 1ns/1ps
module dscic_ctrl (
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    input  wire logic                       clk_en,
    input  wire logic                       link_clk,
    input  wire dscic_pkg::dscic_user_req_t user_req_first,
    input  wire dscic_pkg::dscic_user_req_t user_req_second,
    input  wire logic                       second_enable_cmd,
    input  wire logic                       nv_switch_mode,
    input  wire logic                       switch_select,
    input  wire logic                       gpio_out,
    input  wire logic                       gpio_oe,
    input  wire logic                       tray_detect_first,
    input  wire logic                       tray_detect_second,
    input  wire logic                       card_serial_io_first_in,
    input  wire logic                       card_serial_io_second_in,
    output logic                            card_clock_first,
    output logic                            card_clock_second,
    output logic                            card_supply_first,
    output logic                            card_supply_second,
    output logic                            card_supply_first_1v8,
    output logic                            card_supply_second_1v8,
    output logic                            card_reset_first,
    output logic                            card_reset_second,
    output logic                            card_serial_io_first_out,
    output logic                            card_serial_io_first_oe,
    output logic                            card_serial_io_second_out,
    output logic                            card_serial_io_second_oe,
    output dscic_pkg::dscic_if_status_t     status_first,
    output dscic_pkg::dscic_if_status_t     status_second,
    output logic                            shared_pin_twenty_six_out,
    output logic                            shared_pin_twenty_six_oe
);
    import dscic_pkg::*;

    typedef struct packed {
        logic [1:0]                        tray_m1;
        logic [1:0]                        tray_m2;
        logic [1:0]                        tray_m3;
        logic [1:0]                        io_m1;
        logic [1:0]                        io_m2;
        logic [1:0]                        io_m3;
        logic [1:0]                        present;
        logic [1:0]                        io_level;
        logic [1:0]                        enabled;
        dscic_ifstate_t [1:0]              state;
        logic [1:0]                        drive_on;
        logic                              mode_caught;
        logic                              switch_mode;
        logic                              pin_out;
        logic                              pin_oe;
        dscic_if_status_t [1:0]            status;
    } dscic_ctrl_state_t;

    logic [1:0]                 rst_pipe;
    logic                       rst_n;
    dscic_ctrl_state_t          s;
    dscic_ctrl_state_t          next_s;
    logic [1:0]                 tray_pin;
    logic [1:0]                 io_pin;
    dscic_user_req_t [1:0]      req;
    dscic_pad_out_t  [1:0]      pad;

    assign tray_pin = {tray_detect_second, tray_detect_first};
    assign io_pin   = {card_serial_io_second_in, card_serial_io_first_in};
    assign req      = {user_req_second, user_req_first};

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops; core state uses rst_n, pad stages take arst_n
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////
    // next-state logic for both interfaces and the shared pin
    always_comb begin
        next_s = s;
        // pin inputs pass three flops; a change counts once 2nd and 3rd agree
        next_s.tray_m1 = tray_pin;
        next_s.tray_m2 = s.tray_m1;
        next_s.tray_m3 = s.tray_m2;
        next_s.io_m1   = io_pin;
        next_s.io_m2   = s.io_m1;
        next_s.io_m3   = s.io_m2;
        for (int i = 0; i < DSCIC_NUM_IF; i++) begin
            if (s.tray_m2[i] == s.tray_m3[i]) begin
                next_s.present[i] = ~s.tray_m3[i];
            end
            if (s.io_m2[i] == s.io_m3[i]) begin
                next_s.io_level[i] = s.io_m3[i];
            end
        end

        // second interface opens only on the enable command, sticky
        next_s.enabled[DSCIC_IF_FIRST] = DSCIC_FIRST_EN_RST;
        if (second_enable_cmd) begin
            next_s.enabled[DSCIC_IF_SECOND] = 1'h1;
        end

        for (int i = 0; i < DSCIC_NUM_IF; i++) begin
            case (s.state[i])
                DSCIC_ST_OFF: begin
                    if (s.enabled[i] && req[i].power_req && s.present[i]) begin
                        next_s.state[i] = DSCIC_ST_ACTIVE;
                    end
                end
                DSCIC_ST_ACTIVE: begin
                    // removal beats every other request
                    if (!s.present[i]) begin
                        next_s.state[i] = DSCIC_ST_SHUT;
                    end else if (!req[i].power_req || !s.enabled[i]) begin
                        next_s.state[i] = DSCIC_ST_OFF;
                    end
                end
                DSCIC_ST_SHUT: begin
                    // stays down until the host drops its request
                    if (!req[i].power_req) begin
                        next_s.state[i] = DSCIC_ST_OFF;
                    end
                end
                default: begin
                    next_s.state[i] = DSCIC_ST_OFF;
                end
            endcase
            // registered enable level, so no decode glitch reaches the link
            next_s.drive_on[i] = (next_s.state[i] == DSCIC_ST_ACTIVE);
            next_s.status[i].present   = next_s.present[i];
            next_s.status[i].active    = next_s.drive_on[i];
            next_s.status[i].shut_down = (next_s.state[i] == DSCIC_ST_SHUT);
            next_s.status[i].io_level  = next_s.io_level[i];
        end

        // stored switch mode is caught once, first enabled cycle after reset
        if (!s.mode_caught) begin
            next_s.mode_caught = 1'h1;
            next_s.switch_mode = nv_switch_mode;
        end
        if (next_s.switch_mode) begin
            next_s.pin_oe  = 1'h1;
            next_s.pin_out = switch_select ? DSCIC_SEL_SECOND_CARD
                                           : DSCIC_SEL_FIRST_CARD;
        end else begin
            next_s.pin_oe  = gpio_oe;
            next_s.pin_out = gpio_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, frozen while clk_en is low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s             <= '0;
            s.enabled     <= {DSCIC_SECOND_EN_RST, DSCIC_FIRST_EN_RST};
            s.present     <= DSCIC_PRESENT_RST;
            s.switch_mode <= DSCIC_SWITCH_MODE_RST;
            s.tray_m1     <= DSCIC_TRAY_RST;
            s.tray_m2     <= DSCIC_TRAY_RST;
            s.tray_m3     <= DSCIC_TRAY_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one pad stage per interface on the link clock
    for (genvar g = 0; g < DSCIC_NUM_IF; g++) begin : g_pad
        dscic_pad_stage u_pad (
            .link_clk (link_clk),
            .arst_n   (arst_n),
            .drive_on (s.drive_on[g]),
            .req      (req[g]),
            .pad      (pad[g])
        );
    end

    assign card_clock_first          = pad[DSCIC_IF_FIRST].card_clock;
    assign card_clock_second         = pad[DSCIC_IF_SECOND].card_clock;
    assign card_supply_first         = pad[DSCIC_IF_FIRST].card_supply_on;
    assign card_supply_second        = pad[DSCIC_IF_SECOND].card_supply_on;
    assign card_supply_first_1v8     = pad[DSCIC_IF_FIRST].card_supply_1v8;
    assign card_supply_second_1v8    = pad[DSCIC_IF_SECOND].card_supply_1v8;
    assign card_reset_first          = pad[DSCIC_IF_FIRST].card_reset;
    assign card_reset_second         = pad[DSCIC_IF_SECOND].card_reset;
    assign card_serial_io_first_out  = pad[DSCIC_IF_FIRST].io_out;
    assign card_serial_io_first_oe   = pad[DSCIC_IF_FIRST].io_oe;
    assign card_serial_io_second_out = pad[DSCIC_IF_SECOND].io_out;
    assign card_serial_io_second_oe  = pad[DSCIC_IF_SECOND].io_oe;
    assign status_first              = s.status[DSCIC_IF_FIRST];
    assign status_second             = s.status[DSCIC_IF_SECOND];
    assign shared_pin_twenty_six_out = s.pin_out;
    assign shared_pin_twenty_six_oe  = s.pin_oe;

    ////////////////////////////////////////////////////////////////////////
    // checks on the core-domain control
    for (genvar g = 0; g < DSCIC_NUM_IF; g++) begin : g_chk
        a_removal_shuts: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (clk_en && s.state[g] == DSCIC_ST_ACTIVE && !s.present[g])
            |=> (s.state[g] == DSCIC_ST_SHUT && !s.drive_on[g]))
            else $error("removed card not shut down next cycle");

        a_tray_polarity: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (clk_en && s.tray_m2[g] == s.tray_m3[g])
            |=> (s.present[g] == !$past(s.tray_m3[g])))
            else $error("tray level not decoded active low");

        a_shut_holds: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (s.state[g] == DSCIC_ST_SHUT && req[g].power_req)
            |=> (s.state[g] == DSCIC_ST_SHUT && !s.drive_on[g]))
            else $error("shut interface left shutdown on its own");

        a_drive_state: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            s.drive_on[g] == (s.state[g] == DSCIC_ST_ACTIVE))
            else $error("drive level disagrees with interface state");

        a_off_waits: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (clk_en && s.state[g] == DSCIC_ST_OFF
             && !(s.enabled[g] && req[g].power_req && s.present[g]))
            |=> (s.state[g] == DSCIC_ST_OFF))
            else $error("interface powered without enable, request and tray");

        // a single disagreeing sample must never move the presence flag
        a_tray_filter: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (clk_en && s.tray_m2[g] != s.tray_m3[g])
            |=> $stable(s.present[g]))
            else $error("tray presence moved on a disagreeing sample");

        a_shut_release: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (clk_en && s.state[g] == DSCIC_ST_SHUT && !req[g].power_req)
            |=> (s.state[g] == DSCIC_ST_OFF && !s.drive_on[g]))
            else $error("shut interface not released to off");

        a_shut_status: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (s.state[g] == DSCIC_ST_SHUT)
            |-> (s.status[g].shut_down && !s.status[g].active))
            else $error("shutdown not reported on status");
    end

    a_second_gated: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !s.enabled[DSCIC_IF_SECOND]
        |-> s.state[DSCIC_IF_SECOND] != DSCIC_ST_ACTIVE)
        else $error("second interface active before enable command");

    a_first_enabled: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s.enabled[DSCIC_IF_FIRST])
        else $error("first interface not enabled");

    a_switch_level: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && s.mode_caught && s.switch_mode)
        |=> (shared_pin_twenty_six_oe
             && shared_pin_twenty_six_out == $past(switch_select)))
        else $error("switch select level wrong");

    a_pin_locked: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (s.mode_caught && s.switch_mode && !gpio_oe)
        |=> shared_pin_twenty_six_oe)
        else $error("general use reached a locked shared pin");

    a_mode_stable: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s.mode_caught |=> $stable(s.switch_mode))
        else $error("switch mode changed without restart");

    // the enable command cannot be taken back short of a reset
    a_second_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s.enabled[DSCIC_IF_SECOND] |=> s.enabled[DSCIC_IF_SECOND])
        else $error("second interface enable lost without reset");

    a_gpio_pass: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && s.mode_caught && !s.switch_mode)
        |=> (shared_pin_twenty_six_oe == $past(gpio_oe)
             && shared_pin_twenty_six_out == $past(gpio_out)))
        else $error("general use not passed to the shared pin");

endmodule : dscic_ctrl

// ### bench/dscic_card_model.sv
/*
 * Model of one removable card in its holder, behind one card interface.
 * Assumes the serial data pad has a pull-up and the holder switch
 * grounds the tray-detect line while a tray sits in the holder.
 */
`timescale 1ns/1ps
module dscic_card_model (
    input  wire logic supply,
    input  wire logic io_oe,
    input  wire logic io_out,
    input  wire logic inserted,
    input  wire logic pull_low,
    output logic      tray,
    output logic      io_level
);
    ////////////////////////////////////////////////////////////////////////
    // holder switch closes to ground with a tray in; wired for nothing else
    assign tray = inserted ? 1'h0 : 1'h1;

    // open-drain line: an unpowered card cannot pull, so pull-up wins
    assign io_level = ((io_oe && !io_out) ||
                       (inserted && supply && pull_low)) ? 1'h0 : 1'h1;
endmodule : dscic_card_model

// ### bench/tb_dual_smart_card_interface_control.sv
/*
 * Self-checking bench for the dual card interface control.
 * Assumes dscic_ctrl is the top, a 40 MHz core clock and a 12 ns link clock.
 */
`timescale 1ns/1ps
module tb_dual_smart_card_interface_control;
    import dscic_pkg::*;
    logic             core_clk  = 1'h0;
    logic             link_clk  = 1'h0;
    logic             arst_n    = 1'h0;
    logic             clk_en    = 1'h1;
    dscic_user_req_t  req_a     = '0;
    dscic_user_req_t  req_b     = '0;
    logic             second_en = 1'h0;
    logic             nv_mode   = 1'h0;
    logic             sel       = 1'h0;
    logic             g_out     = 1'h0;
    logic             g_oe      = 1'h0;
    logic             ins_a     = 1'h1;
    logic             ins_b     = 1'h1;
    logic             pl_a      = 1'h0;
    logic             pl_b      = 1'h0;
    logic             tray_a, tray_b, io_a, io_b, clk_a, clk_b;
    logic             sup_a, sup_b, v18_a, v18_b, rst_a, rst_b;
    logic             out_a, oe_a, out_b, oe_b, sp_out, sp_oe;
    dscic_if_status_t st_a, st_b;
    int               err_count = 0;
    int               n_tests   = 0;
    int               cycles    = 0;
    int               tog;

    ////////////////////////////////////////////////////////////////////////
    // clocks: periods 25 ns and 12 ns; rising edges never meet, phase repeats every 300 ns
    always #12.5 core_clk = ~core_clk;
    always #6 link_clk = ~link_clk;

    dscic_ctrl dut (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
        .link_clk(link_clk), .user_req_first(req_a), .user_req_second(req_b),
        .second_enable_cmd(second_en), .nv_switch_mode(nv_mode),
        .switch_select(sel), .gpio_out(g_out), .gpio_oe(g_oe),
        .tray_detect_first(tray_a), .tray_detect_second(tray_b),
        .card_serial_io_first_in(io_a), .card_serial_io_second_in(io_b),
        .card_clock_first(clk_a), .card_clock_second(clk_b),
        .card_supply_first(sup_a), .card_supply_second(sup_b),
        .card_supply_first_1v8(v18_a), .card_supply_second_1v8(v18_b),
        .card_reset_first(rst_a), .card_reset_second(rst_b),
        .card_serial_io_first_out(out_a), .card_serial_io_first_oe(oe_a),
        .card_serial_io_second_out(out_b), .card_serial_io_second_oe(oe_b),
        .status_first(st_a), .status_second(st_b),
        .shared_pin_twenty_six_out(sp_out), .shared_pin_twenty_six_oe(sp_oe)
    );

    dscic_card_model u_card_a (.supply(sup_a), .io_oe(oe_a),
        .io_out(out_a), .inserted(ins_a), .pull_low(pl_a), .tray(tray_a),
        .io_level(io_a));
    dscic_card_model u_card_b (.supply(sup_b), .io_oe(oe_b),
        .io_out(out_b), .inserted(ins_b), .pull_low(pl_b), .tray(tray_b),
        .io_level(io_b));

    ////////////////////////////////////////////////////////////////////////
    // verdict and run end, reached from the main sequence or the timeout
    task automatic close_out;
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // inputs always move 2 ns after the core edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : step

    task automatic do_reset(input logic mode);
        arst_n = 1'h0;
        nv_mode = mode;
        step(12);
        arst_n = 1'h1;
        step(4);
    endtask : do_reset

    // card clock edges seen over 8 link periods, then back on the core grid
    task automatic count_clk(input logic which, output int n);
        logic last;
        n = 0;
        last = which ? clk_b : clk_a;
        repeat (8) begin
            @(posedge link_clk);
            #1;
            if ((which ? clk_b : clk_a) !== last) n++;
            last = which ? clk_b : clk_a;
        end
        step(1);
    endtask : count_clk

    // pads {supply, 1v8, reset, io_oe, io_out}; off parks data low
    function automatic logic [4:0] pads(input int on,
                                        input dscic_user_req_t r);
        return on ? {1'h1, r.volt_1v8, r.reset_release, r.io_drive_low, 1'h0}
                  : 5'h02;
    endfunction : pads

    ////////////////////////////////////////////////////////////////////////
    // hang guard: whole sequence needs well under 1500 core cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        void'($urandom(32'h83293aab));
        do_reset(1'h0);
        // second interface asked for power before any enable command
        req_b = 5'h12;
        step(10);
        chk(st_b, 8'h08);
        chk({sup_b, v18_b, rst_b, oe_b, out_b}, pads(0, req_b));
        count_clk(1'h1, tog);
        chk(8'(tog), 8'h00);
        // first interface with random classes, reset and data levels
        for (int i = 0; i < 6; i++) begin
            req_a = 5'($urandom());
            req_a.power_req = 1'h1;
            req_a.clk_run = 1'h1;
            pl_a = 1'($urandom());
            step(10);
            chk({sup_a, v18_a, rst_a, oe_a, out_a}, pads(1, req_a));
            chk(st_a, {3'h6, !(req_a.io_drive_low || pl_a)});
            count_clk(1'h0, tog);
            chk(8'(tog > 0), 8'h01);
        end
        // tray pulled out under a running card
        ins_a = 1'h0;
        step(10);
        chk(st_a, 8'h02);
        chk({sup_a, v18_a, rst_a, oe_a, out_a}, pads(0, req_a));
        count_clk(1'h0, tog);
        chk(8'(tog), 8'h00);
        req_a.power_req = 1'h0;
        step(3);
        chk(st_a, 8'h00);
        ins_a = 1'h1;
        step(10);
        do_reset(1'h0);
        // enable command pulse, then both interfaces run side by side
        req_a = 5'h1a;
        second_en = 1'h1;
        step(1);
        second_en = 1'h0;
        pl_b = 1'h1;
        step(10);
        chk(st_b, 8'h0c);
        chk(st_a, {3'h6, !pl_a});
        chk({sup_b, v18_b, rst_b, oe_b, out_b}, pads(1, req_b));
        count_clk(1'h1, tog);
        chk(8'(tog > 0), 8'h01);
        // frozen core keeps the second interface up despite a request drop
        clk_en = 1'h0;
        req_b.power_req = 1'h0;
        step(4);
        chk(st_b, 8'h0c);
        chk(8'(sup_b), 8'h01);
        clk_en = 1'h1;
        step(10);
        chk(st_b, 8'h08);
        chk({sup_b, v18_b, rst_b, oe_b, out_b}, pads(0, req_b));
        // stored mode changed in mid-run stays dormant until restart
        nv_mode = 1'h1;
        for (int i = 0; i < 4; i++) begin
            {g_out, g_oe, sel} = 3'($urandom());
            step(2);
            chk({sp_out, sp_oe}, {g_out, g_oe});
        end
        // after restart the shared pin belongs to the card switch
        do_reset(1'h1);
        nv_mode = 1'h0;
        for (int i = 0; i < 6; i++) begin
            {g_out, g_oe, sel} = (i < 2) ? {2'h3, i[0]} : 3'($urandom());
            step(2);
            chk({sp_out, sp_oe}, {sel, 1'h1});
        end
        close_out();
    end
endmodule : tb_dual_smart_card_interface_control
